// [design/luma_noise_reduction_edge_filter.sv]
// luma enhancement datapath with input fifo and register file
`timescale 1ns/1ns
`default_nettype none

// ========================================
// fifo of flip-flops with valid and ready on both sides
module pixel_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;
    logic [AW:0] next_level;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = level != '0;
    assign out_data = mem[rd_ptr];
    assign next_level = level + (AW + 1)'(push) - (AW + 1)'(pop);

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
            in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            level <= next_level;
            in_ready <= next_level != (AW + 1)'(DEPTH);
        end
    end
endmodule : pixel_fifo

// ========================================
// top: register file, block noise coring, hd shaping, edge control
module luma_noise_reduction_edge_filter
    import luma_filter_pkg::*;
#(
    parameter int DEPTH = luma_filter_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic sd_mode,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic [7:0] pix_luma,
    input wire logic [7:0] pix_chroma,
    input wire logic pix_line_start,
    input wire logic pix_line_end,
    input wire logic pix_field_start,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_luma,
    output logic [7:0] out_chroma,
    output logic out_line_start,
    output logic out_line_end
);
    import luma_filter_pkg::*;

    // ========================================
    // register file
    logic [7:0] hd_mode, sharp_gain, gain1, gain2, gain3;
    logic [7:0] thr_a, thr_b, thr_c, edge_ctrl;
    logic [7:0] coring_gain, noise_setup, noise_mode;
    logic [$clog2(DEPTH):0] fifo_level;

    always_ff @(posedge clock) begin
        if (srst) begin
            hd_mode <= REG_RESET;
            sharp_gain <= REG_RESET;
            gain1 <= REG_RESET;
            gain2 <= REG_RESET;
            gain3 <= REG_RESET;
            thr_a <= REG_RESET;
            thr_b <= REG_RESET;
            thr_c <= REG_RESET;
            edge_ctrl <= REG_RESET;
            coring_gain <= REG_RESET;
            noise_setup <= REG_RESET;
            noise_mode <= REG_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                ADDR_HD_MODE: hd_mode <= reg_wdata;
                ADDR_SHARP_GAIN: sharp_gain <= reg_wdata;
                ADDR_ADAPT_GAIN1: gain1 <= reg_wdata;
                ADDR_ADAPT_GAIN2: gain2 <= reg_wdata;
                ADDR_ADAPT_GAIN3: gain3 <= reg_wdata;
                ADDR_ADAPT_THR_A: thr_a <= reg_wdata;
                ADDR_ADAPT_THR_B: thr_b <= reg_wdata;
                ADDR_ADAPT_THR_C: thr_c <= reg_wdata;
                ADDR_EDGE_CTRL: edge_ctrl <= reg_wdata;
                ADDR_CORING_GAIN: coring_gain <= reg_wdata;
                ADDR_NOISE_SETUP: noise_setup <= reg_wdata;
                ADDR_NOISE_MODE: noise_mode <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_HD_MODE: reg_rdata <= hd_mode;
                ADDR_SHARP_GAIN: reg_rdata <= sharp_gain;
                ADDR_ADAPT_GAIN1: reg_rdata <= gain1;
                ADDR_ADAPT_GAIN2: reg_rdata <= gain2;
                ADDR_ADAPT_GAIN3: reg_rdata <= gain3;
                ADDR_ADAPT_THR_A: reg_rdata <= thr_a;
                ADDR_ADAPT_THR_B: reg_rdata <= thr_b;
                ADDR_ADAPT_THR_C: reg_rdata <= thr_c;
                ADDR_EDGE_CTRL: reg_rdata <= edge_ctrl;
                ADDR_CORING_GAIN: reg_rdata <= coring_gain;
                ADDR_NOISE_SETUP: reg_rdata <= noise_setup;
                ADDR_NOISE_MODE: reg_rdata <= noise_mode;
                ADDR_FIFO_LEVEL: reg_rdata <= 8'(fifo_level);
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ========================================
    // input fifo
    logic f_valid, take;
    logic [WORD_WIDTH-1:0] f_word;
    logic [7:0] x, f_chroma;
    logic f_ls, f_le, f_fs;

    pixel_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clock(clock),
        .srst(srst),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data({pix_field_start, pix_line_start, pix_line_end,
                  pix_chroma, pix_luma}),
        .out_valid(f_valid),
        .out_ready(take),
        .out_data(f_word),
        .level(fifo_level)
    );

    assign take = f_valid && (!out_valid || out_ready);
    assign {f_fs, f_ls, f_le, f_chroma, x} = f_word;

    // ========================================
    // position counters
    logic [15:0] pix_cnt, cur_idx, line_len;
    logic [15:0] row_cnt, cur_row;
    logic [7:0] hist [8];
    logic [7:0] last_luma;

    assign cur_idx = f_ls ? 16'h0000 : pix_cnt;
    assign cur_row = f_fs ? 16'h0000 : (f_ls ? row_cnt + 16'h0001 : row_cnt);

    always_ff @(posedge clock) begin
        if (srst) begin
            pix_cnt <= 16'h0000;
            row_cnt <= 16'h0000;
            line_len <= LINE_LEN_RESET;
        end else if (take) begin
            pix_cnt <= cur_idx + 16'h0001;
            row_cnt <= cur_row;
            if (f_le) begin
                line_len <= cur_idx + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < 8; i++) begin
                hist[i] <= 8'h00;
            end
        end else if (take) begin
            hist[0] <= x;
            for (int i = 1; i < 8; i++) begin
                hist[i] <= hist[i-1];
            end
        end
    end

    // ========================================
    // block noise coring (standard definition)
    logic core_sharpen, border4, block16, in_border;
    logic [3:0] blk_off, hpos, vpos, mask, code, csat;
    logic [2:0] half;
    logic [4:0] bsize, g16;
    logic signed [9:0] sd_diff, hp, mag;
    logic signed [15:0] sd_prod;
    logic signed [11:0] sd_y;
    logic [5:0] thr;
    logic is_noise, is_detail;

    assign core_sharpen = noise_mode[CORE_MODE_BIT];
    assign blk_off = noise_mode[BLOCK_OFFSET_LSB +: 4];
    assign border4 = noise_setup[BORDER4_BIT];
    assign block16 = noise_setup[BLOCK16_BIT];
    assign thr = noise_setup[5:0];
    assign mask = block16 ? 4'hF : 4'h7;
    assign bsize = block16 ? 5'h10 : 5'h08;
    assign half = border4 ? 3'h2 : 3'h1;
    assign hpos = (cur_idx[3:0] + blk_off) & mask;
    assign vpos = cur_row[3:0] & mask;
    assign in_border = ({1'b0, hpos} < 5'(half))
        || ({1'b0, hpos} >= bsize - 5'(half))
        || ({1'b0, vpos} < 5'(half))
        || ({1'b0, vpos} >= bsize - 5'(half));
    assign code = in_border ? coring_gain[3:0] : coring_gain[7:4];
    assign csat = (code > GAIN_SAT_CODE) ? GAIN_SAT_CODE : code;
    assign g16 = core_sharpen ? {1'b0, csat} : {csat, 1'b0};

    assign sd_diff = $signed({2'b00, x})
        - $signed({2'b00, hist[noise_mode[2:0]]});
    assign hp = sd_diff >>> 1;
    assign mag = hp[9] ? -hp : hp;
    assign is_noise = mag < $signed({4'h0, thr});
    assign is_detail = mag > $signed({4'h0, thr});
    assign sd_prod = 16'(hp * $signed({1'b0, g16}));

    always_comb begin
        sd_y = $signed({4'h0, x});
        if (!core_sharpen && is_noise) begin
            sd_y = sd_y - 12'(sd_prod >>> 4);
        end else if (core_sharpen && is_detail) begin
            sd_y = sd_y + 12'(sd_prod >>> 4);
        end
    end

    // ========================================
    // sharpness and adaptive shaping (high definition)
    logic sharp_en, adapt_en, adapt_cascade;
    logic [9:0] lpf_sum;
    logic signed [9:0] hp_a, hp_b, deriv;
    logic [7:0] gset;
    logic signed [3:0] g_a, g_b;
    logic signed [15:0] hd_term;
    logic signed [11:0] hd_y;

    assign sharp_en = hd_mode[HD_SHARP_EN_BIT];
    assign adapt_en = hd_mode[HD_ADAPT_EN_BIT];
    assign adapt_cascade = hd_mode[HD_ADAPT_MODE_BIT];
    assign lpf_sum = {2'b00, x} + {1'b0, hist[0], 1'b0} + {2'b00, hist[1]};
    assign hp_b = $signed({2'b00, hist[0]}) - $signed({2'b00, lpf_sum[9:2]});
    assign hp_a = ($signed({2'b00, x}) - $signed({2'b00, hist[1]})) >>> 1;
    assign deriv = $signed({2'b00, x}) - $signed({2'b00, hist[0]});

    always_comb begin
        gset = sharp_gain;
        if (adapt_en) begin
            if ((deriv[9] ? -deriv : deriv) > $signed({2'b00, thr_a})) begin
                gset = gain3;
            end else if ((deriv[9] ? -deriv : deriv)
                    > $signed({2'b00, thr_b})) begin
                gset = gain2;
            end else if ((deriv[9] ? -deriv : deriv)
                    > $signed({2'b00, thr_c})) begin
                gset = gain1;
            end
        end
    end

    always_comb begin
        g_a = $signed(gset[3:0]);
        g_b = $signed(gset[7:4]);
        hd_term = 16'(hp_a * g_a) + 16'(hp_b * g_b);
        if (adapt_en && !adapt_cascade) begin
            g_a = $signed(GAIN_A_FIXED);
            hd_term = 16'(hp_b * g_b);
        end
        hd_y = $signed({4'h0, x});
        if (sharp_en) begin
            hd_y = hd_y + 12'(hd_term >>> 3);
        end
    end

    // ========================================
    // active video edge scaling and step limiting
    logic [7:0] y_clip, y_scaled, y_final, prev_ref;
    logic [15:0] from_end;
    logic at_first, at_last, edge_on;
    logic [1:0] edge_k;
    logic signed [9:0] step;

    assign y_clip = (sd_mode ? sd_y : hd_y) < 0 ? 8'h00
        : ((sd_mode ? sd_y : hd_y) > 12'sd255 ? 8'hFF
        : 8'(sd_mode ? sd_y : hd_y));
    assign from_end = line_len - 16'h0001 - cur_idx;
    assign at_first = cur_idx < 16'h0003;
    assign at_last = (cur_idx < line_len) && (from_end < 16'h0003);
    assign edge_on = sd_mode && edge_ctrl[EDGE_EN_BIT]
        && (at_first || at_last);
    assign edge_k = at_first ? cur_idx[1:0] : from_end[1:0];
    assign prev_ref = f_ls ? BLACK_LEVEL : last_luma;

    always_comb begin
        y_scaled = y_clip;
        case (edge_k)
            2'h0: y_scaled = y_clip >> 3;
            2'h1: y_scaled = y_clip >> 1;
            2'h2: y_scaled = y_clip - (y_clip >> 3);
            default: y_scaled = y_clip;
        endcase
        step = $signed({2'b00, y_scaled}) - $signed({2'b00, prev_ref});
        y_final = y_clip;
        if (edge_on) begin
            y_final = y_scaled;
            if (step > $signed({2'b00, STEP_LIMIT})) begin
                y_final = prev_ref + STEP_LIMIT;
            end else if (step < -$signed({2'b00, STEP_LIMIT})) begin
                y_final = prev_ref - STEP_LIMIT;
            end
        end
    end

    // ========================================
    // output stage
    always_ff @(posedge clock) begin
        if (srst) begin
            out_valid <= 1'b0;
        end else if (take) begin
            out_valid <= 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            out_luma <= 8'h00;
            out_chroma <= 8'h00;
            out_line_start <= 1'b0;
            out_line_end <= 1'b0;
            last_luma <= BLACK_LEVEL;
        end else if (take) begin
            out_luma <= y_final;
            out_chroma <= f_chroma;
            out_line_start <= f_ls;
            out_line_end <= f_le;
            last_luma <= y_final;
        end
    end

    // ========================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_chroma_passes: assert property (
        take |=> out_chroma == $past(f_chroma))
        else $error("chroma altered");
    a_hd_bypass: assert property (
        take && !sd_mode && !sharp_en |=> out_luma == $past(x))
        else $error("hd luma changed with sharpness off");
    a_coring_pass: assert property (
        take && sd_mode && !edge_ctrl[EDGE_EN_BIT] && !core_sharpen
        && !is_noise |=> out_luma == $past(x))
        else $error("coring touched detail");
    a_sharp_quiet: assert property (
        take && sd_mode && !edge_ctrl[EDGE_EN_BIT] && core_sharpen
        && !is_detail |=> out_luma == $past(x))
        else $error("sharpening touched noise");
    a_coring_gain_max: assert property (
        !core_sharpen |-> g16 <= 5'h10 && (code > 4'h7 || g16 == {code, 1'b0}))
        else $error("coring gain out of range");
    a_sharp_gain_max: assert property (
        core_sharpen |-> g16 <= 5'h08)
        else $error("sharpening gain above half");
    a_edge_first: assert property (
        take && sd_mode && edge_ctrl[EDGE_EN_BIT] && f_ls
        |=> out_luma <= FIRST_EDGE_MAX)
        else $error("first edge pixel not scaled");
    a_output_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_luma))
        else $error("output dropped under back-pressure");
    a_line_length: assert property (
        take && f_le |=> line_len == $past(cur_idx) + 16'h0001)
        else $error("line length not captured");

    c_coring_active: cover property (
        take && sd_mode && !core_sharpen && is_noise && g16 != 5'h00);
    c_sharp_active: cover property (
        take && sd_mode && core_sharpen && is_detail && g16 != 5'h00);
    c_fifo_full: cover property (!pix_ready ##1 pix_ready);
    c_adaptive_b: cover property (take && !sd_mode && adapt_en
        && adapt_cascade);
endmodule : luma_noise_reduction_edge_filter

`default_nettype wire

// [design/luma_filter_pkg.sv]
// package: register map, field positions and constants of the luma filter
package luma_filter_pkg;
    // ========================================
    // register offsets
    localparam logic [7:0] ADDR_HD_MODE = 8'h15;
    localparam logic [7:0] ADDR_SHARP_GAIN = 8'h20;
    localparam logic [7:0] ADDR_ADAPT_GAIN1 = 8'h38;
    localparam logic [7:0] ADDR_ADAPT_GAIN2 = 8'h39;
    localparam logic [7:0] ADDR_ADAPT_GAIN3 = 8'h3A;
    localparam logic [7:0] ADDR_ADAPT_THR_A = 8'h3B;
    localparam logic [7:0] ADDR_ADAPT_THR_B = 8'h3C;
    localparam logic [7:0] ADDR_ADAPT_THR_C = 8'h3D;
    localparam logic [7:0] ADDR_EDGE_CTRL = 8'h42;
    localparam logic [7:0] ADDR_CORING_GAIN = 8'h63;
    localparam logic [7:0] ADDR_NOISE_SETUP = 8'h64;
    localparam logic [7:0] ADDR_NOISE_MODE = 8'h65;
    localparam logic [7:0] ADDR_FIFO_LEVEL = 8'h7E;
    // ========================================
    // field positions
    localparam int HD_ADAPT_EN_BIT = 7;
    localparam int HD_ADAPT_MODE_BIT = 6;
    localparam int HD_SHARP_EN_BIT = 5;
    localparam int EDGE_EN_BIT = 7;
    localparam int BLOCK16_BIT = 7;
    localparam int BORDER4_BIT = 6;
    localparam int CORE_MODE_BIT = 4;
    localparam int BLOCK_OFFSET_LSB = 4;
    // ========================================
    // reset values and fixed numbers
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [3:0] GAIN_A_FIXED = 4'h1;
    localparam logic [3:0] GAIN_SAT_CODE = 4'h8;
    localparam logic [7:0] STEP_LIMIT = 8'h40;
    localparam logic [7:0] BLACK_LEVEL = 8'h10;
    localparam logic [7:0] FIRST_EDGE_MAX = 8'h1F;
    localparam logic [15:0] LINE_LEN_RESET = 16'h02D0;
    localparam int LUMA_WIDTH = 8;
    localparam int WORD_WIDTH = 2 * LUMA_WIDTH + 3;
    localparam int FIFO_DEPTH = 16;
endpackage : luma_filter_pkg

// [verif/pixel_source.sv]
// pixel source model: hands queued words to the filter, with gaps
`timescale 1ns/1ns
`default_nettype none
module pixel_source (
    input wire logic clock,
    input wire logic srst,
    input wire logic pix_ready,
    output logic pix_valid,
    output logic [7:0] pix_luma,
    output logic [7:0] pix_chroma,
    output logic pix_line_start,
    output logic pix_line_end,
    output logic pix_field_start
);
    logic [18:0] q[$];
    logic [18:0] w = 19'h0;
    int gap_pct = 0;
    int taken = 0;
    bit acc = 1'b0;
    initial begin
        pix_valid = 1'b0;
        {pix_luma, pix_chroma, pix_line_start, pix_line_end,
            pix_field_start} = 19'h0;
    end
    always @(posedge clock) begin
        acc = pix_valid && pix_ready;
        if (acc) begin
            taken++;
        end
    end
    // a word stands until taken; idle lines carry junk, not the last word
    always @(negedge clock) begin
        if (srst) begin
            pix_valid <= 1'b0;
        end else if (!pix_valid || acc) begin
            if (q.size() > 0 && $urandom_range(99) >= gap_pct) begin
                w = q.pop_front();
                pix_valid <= 1'b1;
            end else begin
                w = ~w;
                pix_valid <= 1'b0;
            end
            {pix_luma, pix_chroma, pix_line_start, pix_line_end,
                pix_field_start} <= w;
        end
    end
endmodule : pixel_source
`default_nettype wire

// [verif/tb.sv]
// self-checking bench of the luma filter
`timescale 1ns/1ns
`default_nettype none
module tb;
    import luma_filter_pkg::*;
    localparam int DEPTH = 16;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic sd_mode = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic out_ready = 1'b0;
    logic [7:0] reg_rdata, pix_luma, pix_chroma, out_luma, out_chroma;
    logic pix_valid, pix_ready, pix_line_start, pix_line_end;
    logic pix_field_start, out_valid, out_line_start, out_line_end;
    logic [18:0] exp_q[$];
    logic [18:0] e;
    int err_total = 0;
    int check_count = 0;
    int stall_pct = 0;
    logic [7:0] ra[5] = '{ADDR_HD_MODE, ADDR_EDGE_CTRL, ADDR_CORING_GAIN,
        ADDR_NOISE_SETUP, ADDR_NOISE_MODE};
    logic [7:0] wv[5] = '{8'h40, 8'h80, 8'hC3, 8'hFF, 8'h57};
    logic [7:0] cm[8] = '{8'h00, 8'h03, 8'h01, 8'h12, 8'h17, 8'h10,
        8'h00, 8'h20};
    logic [7:0] cg[8] = '{8'h88, 8'hFF, 8'h44, 8'h88, 8'hFF, 8'h88,
        8'h80, 8'h08};
    logic [7:0] ct[8] = '{8'hC3, 8'h03, 8'h02, 8'h01, 8'h01, 8'h3F,
        8'h03, 8'h03};
    int cd[8] = '{-2, -2, 0, 1, 1, 0, -2, -2};

    luma_noise_reduction_edge_filter #(.DEPTH(DEPTH)) i_dut (
        .clock(clock), .srst(srst), .sd_mode(sd_mode),
        .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_luma(pix_luma), .pix_chroma(pix_chroma),
        .pix_line_start(pix_line_start), .pix_line_end(pix_line_end),
        .pix_field_start(pix_field_start), .out_valid(out_valid),
        .out_ready(out_ready), .out_luma(out_luma),
        .out_chroma(out_chroma), .out_line_start(out_line_start),
        .out_line_end(out_line_end)
    );
    pixel_source src (
        .clock(clock), .srst(srst), .pix_ready(pix_ready),
        .pix_valid(pix_valid), .pix_luma(pix_luma),
        .pix_chroma(pix_chroma), .pix_line_start(pix_line_start),
        .pix_line_end(pix_line_end), .pix_field_start(pix_field_start)
    );

    always #25 clock = ~clock;
    always @(negedge clock) out_ready <= ($urandom_range(99) >= stall_pct);

    // ========================================
    // shared tasks
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] expd);
        check_count++;
        if (seen !== expd) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, expd, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_read = 1'b0;
        d = reg_rdata;
    endtask : rd
    // f is {line start, line end, field start}; chk enables the luma compare
    task automatic push(input logic [7:0] y, input logic [7:0] c,
        input logic [2:0] f, input logic [7:0] ye, input logic chk);
        src.q.push_back({y, c, f});
        exp_q.push_back({chk, ye, c, f[2:1]});
    endtask : push
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        if (exp_q.size() > 0) begin
            err_total++;
            $display("Error drain expected 0 seen %0d", exp_q.size());
            print_verdict();
        end
    endtask : drain

    // ========================================
    // output watcher: every accepted word against the oldest note
    always @(posedge clock) begin
        if (!srst && out_valid === 1'b1 && out_ready) begin
            if (exp_q.size() == 0) begin
                check("spare word", 8'h01, 8'h00);
            end else begin
                e = exp_q.pop_front();
                if (e[18]) begin
                    check("luma", out_luma, e[17:10]);
                end
                check("chroma", out_chroma, e[9:2]);
                check("flags", {6'h0, out_line_start, out_line_end},
                    {6'h0, e[1:0]});
            end
        end
    end

    // ========================================
    // main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] y;
        int i, j, t, t0, prev, dly, lim;
        i = $urandom(32571);
        lim = int'(STEP_LIMIT);
        repeat (6) @(negedge clock);
        srst = 1'b0;
        for (i = 0; i < 5; i++) begin
            rd(ra[i], d);
            check("reset value", d, REG_RESET);
            wr(ra[i], wv[i]);
            rd(ra[i], d);
            check("read back", d, wv[i]);
        end
        wr(8'h01, 8'hFF);
        rd(8'h01, d);
        check("unmapped", d, 8'h00);
        wr(ADDR_FIFO_LEVEL, 8'h55);
        rd(ADDR_FIFO_LEVEL, d);
        check("level idle", d, 8'h00);
        for (i = 0; i < 5; i++) begin
            wr(ra[i], 8'h00);
        end
        $display("test registers done");
        src.gap_pct = 30;
        stall_pct = 30;
        for (j = 0; j < 2; j++) begin
            sd_mode = j[0];
            for (i = 0; i < 64; i++) begin
                y = 8'($urandom);
                push(y, 8'($urandom), {i % 8 == 0, i % 8 == 7, i == 0}, y,
                    1'b1);
            end
            drain();
        end
        $display("test random pass-through done");
        src.gap_pct = 0;
        stall_pct = 100;
        t0 = src.taken;
        for (i = 0; i < 24; i++) begin
            push(8'(i), 8'h80, 3'b000, 8'(i), 1'b1);
        end
        repeat (60) @(negedge clock);
        check("words taken", 8'(src.taken - t0), 8'(DEPTH + 1));
        check("ready when full", {7'h0, pix_ready}, 8'h00);
        rd(ADDR_FIFO_LEVEL, d);
        check("level full", d, 8'(DEPTH));
        stall_pct = 50;
        drain();
        rd(ADDR_FIFO_LEVEL, d);
        check("level empty", d, 8'h00);
        $display("test fill and drain done");
        src.gap_pct = 10;
        stall_pct = 10;
        // lines 6 and 7 carry no field start: interior rows, offset grid
        for (j = 0; j < 8; j++) begin
            wr(ADDR_NOISE_MODE, cm[j]);
            wr(ADDR_CORING_GAIN, cg[j]);
            wr(ADDR_NOISE_SETUP, ct[j]);
            dly = int'(cm[j][2:0]) + 1;
            for (i = 0; i < 16; i++) begin
                y = (i < 6) ? 8'h80 : 8'h84;
                t = (i >= 6 && i < 6 + dly) ? cd[j] : 0;
                push(y, 8'(i * 3), {i == 0, i == 15, i == 0 && j < 6},
                    8'(y + t), i >= dly);
            end
            drain();
        end
        $display("test coring and sharpening done");
        wr(ADDR_NOISE_MODE, 8'h00);
        wr(ADDR_CORING_GAIN, 8'h00);
        wr(ADDR_NOISE_SETUP, 8'h00);
        wr(ADDR_EDGE_CTRL, 8'h80);
        for (j = 0; j < 2; j++) begin
            prev = int'(BLACK_LEVEL);
            for (i = 0; i < 16; i++) begin
                t = 8;
                if (i == 0 || i == 15) begin
                    t = 1;
                end else if (i == 1 || i == 14) begin
                    t = 4;
                end else if (i == 2 || i == 13) begin
                    t = 7;
                end
                t = 248 * t / 8;
                if ((i < 3 || i > 12) && t > prev + lim) begin
                    t = prev + lim;
                end
                if ((i < 3 || i > 12) && t < prev - lim) begin
                    t = prev - lim;
                end
                prev = t;
                push(8'hF8, 8'h80, {i == 0, i == 15, j == 0 && i == 0},
                    8'(t), 1'b1);
            end
        end
        drain();
        $display("test edge control done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
